/* File: src/mmst_top.sv */
// Purpose: management status sequencing of a pluggable transceiver
// Assumes: MCLK 100 MHz; BUS_CLK is the serial bus clock, stands still between frames
// Notes:   bus write/read events come in on BUS_CLK and cross by toggles
`timescale 1ns/100ps
`include "mmst_params.svh"
module mmst_top
  import mmst_pkg::*;
#(
  parameter int INIT_US = `MMST_INIT_READY_US
) (
  // system
  input  wire logic       MCLK,
  input  wire logic       RESET_N,
  // host pins
  input  wire logic       MODULE_RESET_LOW,
  input  wire logic       MODULE_SELECT_LOW,
  input  wire logic       LOW_POWER_REQUEST,
  output logic            INTERRUPT_OUT_LOW,
  // serial bus side, link clock domain
  input  wire logic       BUS_CLK,
  input  wire logic       BUS_WR_STB,
  input  wire logic [3:0] BUS_WR_MASK,
  input  wire logic       BUS_WR_PDOWN,
  input  wire logic       BUS_RD_STB,
  input  wire logic [3:0] BUS_RD_FLAGS,
  // module conditions
  input  wire mmst_cond_t COND,
  // status
  output logic            BUS_ENABLE,
  output logic            LOW_POWER,
  output logic            DATA_NOT_READY,
  output logic [3:0]      FLAGS,
  output logic [3:0]      MASKS
);
  // link domain: capture a write or read on the falling edge after stop
  logic       wr_tgl_reg;
  logic       rd_tgl_reg;
  logic [3:0] bmask_reg;
  logic       bpdn_reg;
  logic [3:0] brd_reg;

  always_ff @(negedge BUS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_tgl_reg <= 1'b0;
      bmask_reg  <= 4'h0;
      bpdn_reg   <= 1'b0;
    end else if (BUS_WR_STB) begin
      wr_tgl_reg <= ~wr_tgl_reg;
      bmask_reg  <= BUS_WR_MASK;
      bpdn_reg   <= BUS_WR_PDOWN;
    end
  end

  always_ff @(negedge BUS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_tgl_reg <= 1'b0;
      brd_reg    <= 4'h0;
    end else if (BUS_RD_STB) begin
      rd_tgl_reg <= ~rd_tgl_reg;
      brd_reg    <= BUS_RD_FLAGS;
    end
  end

  // crossings into MCLK; active-low pins enter inverted so the reset value is idle
  logic [2:0] pins_s;
  logic [1:0] tgl_s;
  logic [3:0] cond_s;
  mmst_sync #(.W(3)) u_pins (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .d     ({~MODULE_RESET_LOW, ~MODULE_SELECT_LOW, LOW_POWER_REQUEST}),
    .q     (pins_s)
  );
  mmst_sync #(.W(2)) u_tgl (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .d     ({wr_tgl_reg, rd_tgl_reg}),
    .q     (tgl_s)
  );
  mmst_sync #(.W(4)) u_cond (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .d     (COND.cond),
    .q     (cond_s)
  );

  wire rst_pin_low = pins_s[2];
  wire sel_act     = pins_s[1];
  wire lp_req      = pins_s[0];

  logic       wr_seen_reg;
  logic       rd_seen_reg;
  logic [3:0] mask_reg;
  logic       pdn_reg;
  logic [3:0] rdclr_reg;
  wire        wr_evt = tgl_s[1] ^ wr_seen_reg;
  wire        rd_evt = tgl_s[0] ^ rd_seen_reg;

  // microsecond tick
  logic [6:0] tick_cnt_reg;
  wire        tick = (tick_cnt_reg == 7'(`MMST_TICK_CYC - 1));
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) tick_cnt_reg <= 7'h00;
    else tick_cnt_reg <= tick ? 7'h00 : tick_cnt_reg + 7'h01;
  end

  // reset pulse qualification: low longer than the minimum pulse
  logic [7:0] rlow_cnt_reg;
  wire        rst_req = (rlow_cnt_reg >= 8'(`MMST_RESET_MIN_CYC));
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) rlow_cnt_reg <= 8'h00;
    else if (!rst_pin_low) rlow_cnt_reg <= 8'h00;
    else if (!rst_req) rlow_cnt_reg <= rlow_cnt_reg + 8'h01;
  end

  // select gating: a change passes at once if select was stable 10 us, else 10 us after it; inside the 100 us bound
  logic [3:0] sel_cnt_reg;
  logic       bus_en_reg;
  logic       sel_last_reg;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sel_cnt_reg  <= 4'h0;
      sel_last_reg <= 1'b0;
    end else begin
      sel_last_reg <= sel_act;
      if (sel_act != sel_last_reg) sel_cnt_reg <= 4'h0;
      else if (tick && sel_cnt_reg != 4'(`MMST_SEL_DLY_US)) sel_cnt_reg <= sel_cnt_reg + 4'h1;
    end
  end
  wire sel_settled = (sel_cnt_reg == 4'(`MMST_SEL_DLY_US));

  // low-power pin settle
  logic [3:0] lp_cnt_reg;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) lp_cnt_reg <= 4'h0;
    else if (!lp_req) lp_cnt_reg <= 4'h0;
    else if (tick && lp_cnt_reg != 4'(`MMST_LP_DLY_US)) lp_cnt_reg <= lp_cnt_reg + 4'h1;
  end
  wire lp_pin_on = (lp_cnt_reg == 4'(`MMST_LP_DLY_US));

  // sequencer
  mmst_state_t state_reg;
  mmst_state_t state_next;
  logic [10:0] seq_cnt_reg;
  logic        dnr_reg;
  wire         lp_any  = lp_pin_on | pdn_reg;
  wire         seq_hit = (state_reg == MMST_ST_INIT) ? (seq_cnt_reg >= 11'(INIT_US))
                                                      : (seq_cnt_reg >= 11'(`MMST_RESUME_US));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MMST_ST_INIT:   if (seq_hit) state_next = MMST_ST_READY;
      MMST_ST_READY:  if (lp_any) state_next = MMST_ST_LOWPWR;
      MMST_ST_LOWPWR: if (!lp_any) state_next = MMST_ST_RESUME;
      MMST_ST_RESUME: begin
        if (lp_any) state_next = MMST_ST_LOWPWR;
        else if (seq_hit) state_next = MMST_ST_READY;
      end
      default:        state_next = MMST_ST_INIT;
    endcase
    if (rst_req) state_next = MMST_ST_INIT;
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg   <= MMST_ST_INIT;
      seq_cnt_reg <= 11'h000;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg || rst_req) seq_cnt_reg <= 11'h000;
      else if (tick && !seq_hit) seq_cnt_reg <= seq_cnt_reg + 11'h001;
    end
  end

  wire in_init = (state_reg == MMST_ST_INIT);

  // data-not-ready: set at start, cleared once init completes
  logic dnr_evt;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dnr_reg <= 1'b1;
      dnr_evt <= 1'b0;
    end else begin
      dnr_evt <= 1'b0;
      if (in_init) dnr_reg <= 1'b1;
      else if (dnr_reg) begin
        dnr_reg <= 1'b0;
        dnr_evt <= 1'b1;
      end
    end
  end

  // write and read events, mask and power-down bits
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_seen_reg <= 1'b0;
      rd_seen_reg <= 1'b0;
      mask_reg    <= 4'h0;
      pdn_reg     <= 1'b0;
      rdclr_reg   <= 4'h0;
    end else begin
      wr_seen_reg <= tgl_s[1];
      rd_seen_reg <= tgl_s[0];
      rdclr_reg   <= rd_evt ? brd_reg : 4'h0;
      if (rst_req) begin
        mask_reg <= 4'h0;
        pdn_reg  <= 1'b0;
      end else if (wr_evt) begin
        mask_reg <= bmask_reg;
        pdn_reg  <= bpdn_reg;
      end
    end
  end

  // sticky flags, set wins over clear-on-read
  logic [3:0] flag_reg;
  logic [3:0] flag_next;
  logic       ready_int_reg;
  genvar gi;
  generate
    for (gi = 0; gi < `MMST_NFLAG; gi++) begin : g_flag
      assign flag_next[gi] = cond_s[gi] | (flag_reg[gi] & ~rdclr_reg[gi]);
    end
  endgenerate

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      flag_reg      <= 4'h0;
      ready_int_reg <= 1'b0;
    end else if (in_init) begin
      flag_reg      <= 4'h0;
      ready_int_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      if (dnr_evt) ready_int_reg <= 1'b1;
      else if (rd_evt) ready_int_reg <= 1'b0;
    end
  end

  wire int_act = ready_int_reg | (|(flag_reg & ~mask_reg));

  // outputs, all registered
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      INTERRUPT_OUT_LOW <= 1'b1;
      bus_en_reg        <= 1'b0;
      LOW_POWER         <= 1'b0;
    end else begin
      INTERRUPT_OUT_LOW <= ~int_act;
      if (sel_settled) bus_en_reg <= sel_act & ~in_init;
      LOW_POWER <= (state_reg == MMST_ST_LOWPWR);
    end
  end

  assign BUS_ENABLE     = bus_en_reg;
  assign DATA_NOT_READY = dnr_reg;
  assign FLAGS          = flag_reg;
  assign MASKS          = mask_reg;

  // checks
  AST_INT_FOLLOWS_FLAG: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (|(flag_reg & ~mask_reg)) |=> !INTERRUPT_OUT_LOW)
    else $error("interrupt not asserted for unmasked flag");
  AST_FLAG_SET: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (cond_s[0] && !in_init) |=> flag_reg[0])
    else $error("flag not set by condition");
  AST_MASK_HOLDS: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (mask_reg == 4'hF && !ready_int_reg && !$past(ready_int_reg)) |=> INTERRUPT_OUT_LOW)
    else $error("masked flags drove interrupt");
  AST_CLEAR_ON_READ: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (rdclr_reg[1] && !cond_s[1] && !in_init) |=> !flag_reg[1])
    else $error("flag not cleared by read");
  AST_SET_WINS: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (rdclr_reg[0] && cond_s[0] && !in_init) |=> flag_reg[0])
    else $error("set lost against clear");
  AST_DNR_IN_TIME: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (in_init ##1 !in_init) |-> ##[1:2] !DATA_NOT_READY)
    else $error("data not ready not cleared");
  AST_READY_INT: assert property (@(posedge MCLK) disable iff (!RESET_N)
    $fell(dnr_reg) |-> ##[1:3] !INTERRUPT_OUT_LOW)
    else $error("ready interrupt missing");
  AST_RESET_REINIT: assert property (@(posedge MCLK) disable iff (!RESET_N)
    rst_req |=> in_init ##1 DATA_NOT_READY)
    else $error("qualified reset did not restart");
  AST_LOWPWR_ENTRY: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (state_reg == MMST_ST_LOWPWR) |=> LOW_POWER)
    else $error("low power not shown");
  AST_BUS_OFF_INIT: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (in_init && $past(in_init) && sel_settled) |=> !BUS_ENABLE)
    else $error("bus enabled during init");
  // bounded latency checks
  AST_TICK_PERIOD: assert property (@(posedge MCLK) disable iff (!RESET_N)
    tick |-> ##100 tick)
    else $error("reference tick period wrong");
  AST_WR_LANDS: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (wr_evt && !rst_req) |=> (MASKS == $past(bmask_reg)))
    else $error("written masks not taken");
  AST_PDN_LOWPWR: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (pdn_reg && !in_init && !rst_req) |-> ##[1:2] LOW_POWER)
    else $error("power-down bit did not lower power");
  AST_LP_PIN_LOWPWR: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (lp_pin_on && !in_init && !rst_req) |-> ##[1:2] LOW_POWER)
    else $error("low-power pin did not lower power");
  AST_SEL_ON: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (sel_settled && sel_act && !in_init) |=> BUS_ENABLE)
    else $error("bus not enabled after select");
  AST_SEL_OFF: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (sel_settled && !sel_act) |=> !BUS_ENABLE)
    else $error("bus still enabled after deselect");
  AST_PIN_HIGH_NO_RESET: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !rst_pin_low |=> !rst_req)
    else $error("reset request without low pin");
  AST_RESUME_LEAVES_LOW: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (state_reg == MMST_ST_LOWPWR && !lp_any && !rst_req) |-> ##[1:2] !LOW_POWER)
    else $error("low power kept after request dropped");
  AST_READ_DROPS_READY: assert property (@(posedge MCLK) disable iff (!RESET_N)
    (rd_evt && !dnr_evt && !in_init) |=> !ready_int_reg)
    else $error("ready interrupt not cleared by read");
endmodule : mmst_top

/* File: src/mmst_params.svh */
// Purpose: constants for the module management status and timing block
// Assumes: system clock at 100 MHz (10 ns)
// Notes:   times are kept in their printed unit; cycle counts derive from them
`ifndef MMST_PARAMS_SVH
`define MMST_PARAMS_SVH

`define MMST_CLK_MHZ          100
`define MMST_TICK_US          1
`define MMST_TICK_CYC         (`MMST_TICK_US * `MMST_CLK_MHZ)
`define MMST_T_INIT_MS        2000
`define MMST_T_RESET_MIN_US   2
`define MMST_T_LOW_POWER_REQUEST_US      100
`define MMST_T_INT_ON_MS      200
`define MMST_T_INT_OFF_US     500
`define MMST_T_LOS_MS         100
`define MMST_T_TXF_MS         200
`define MMST_T_FLAG_MS        200
`define MMST_T_MASK_MS        100
`define MMST_T_SEL_US         100
`define MMST_T_PDN_ON_MS      100
`define MMST_T_PDN_OFF_MS     300
`define MMST_RESET_MIN_CYC    (`MMST_T_RESET_MIN_US * `MMST_CLK_MHZ)
`define MMST_INIT_READY_US    1000
`define MMST_RESUME_US        1000
`define MMST_SEL_DLY_US       10
`define MMST_LP_DLY_US        10
`define MMST_FLAG_BYTE        3
`define MMST_MASK_BYTE_FIRST  100
`define MMST_MASK_BYTE_LAST   106
`define MMST_STATUS_BYTE      2
`define MMST_DNR_BIT          0
`define MMST_NFLAG            4

`endif

/* File: src/mmst_pkg.sv */
// Purpose: types for the module management status and timing block
// Assumes: nothing
// Notes:   flag order los, txfault, other0, other1
package mmst_pkg;
  typedef enum logic [2:0] {
    MMST_ST_INIT,
    MMST_ST_READY,
    MMST_ST_LOWPWR,
    MMST_ST_RESUME
  } mmst_state_t;

  typedef struct packed {
    logic [3:0] cond;
  } mmst_cond_t;

  typedef struct packed {
    logic       stb;
    logic [3:0] mask;
    logic       pdown;
  } mmst_wr_t;
endpackage : mmst_pkg

/* File: src/mmst_sync.sv */
// Purpose: two flip-flop level synchroniser, vector wide
// Assumes: destination clock given on clk
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
module mmst_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : mmst_sync

/* File: tb/mmst_host_model.sv */
// Purpose: host side of the serial bus, sends write and read frames
// Assumes: bus clock period 30 ns, clock stands high between frames
// Notes:   released data lines show the inverse of their last value; strobes return low
`timescale 1ns/100ps
module mmst_host_model
  import mmst_pkg::*;
(
  // serial bus events
  output logic       bus_clk,
  output logic       wr_stb,
  output logic [3:0] wr_mask,
  output logic       wr_pdown,
  output logic       rd_stb,
  output logic [3:0] rd_flags
);
  initial begin
    bus_clk  = 1'b1;
    wr_stb   = 1'b0;
    wr_mask  = 4'h0;
    wr_pdown = 1'b0;
    rd_stb   = 1'b0;
    rd_flags = 4'h0;
  end

  task cyc;
    #15 bus_clk = 1'b0;
    #15 bus_clk = 1'b1;
  endtask : cyc

  // strobe stands over the falling edge after the stop bit
  task frame(input logic wr, input logic [3:0] val, input logic pd);
    repeat (2) cyc();
    if (wr) begin
      wr_stb   = 1'b1;
      wr_mask  = val;
      wr_pdown = pd;
    end else begin
      rd_stb   = 1'b1;
      rd_flags = val;
    end
    cyc();
    wr_stb   = 1'b0;
    rd_stb   = 1'b0;
    wr_mask  = ~wr_mask;
    wr_pdown = ~wr_pdown;
    rd_flags = ~rd_flags;
    cyc();
  endtask : frame
endmodule : mmst_host_model

/* File: tb/testbench.sv */
// Purpose: self-checking bench of the management status block
// Assumes: init shortened to 20 us
// Notes:   resume wait of 1000 us is entered but never run to its end
`timescale 1ns/100ps
module testbench
  import mmst_pkg::*;
;
  typedef struct packed {
    logic [3:0] cond;
    logic [3:0] mask;
    logic       int_exp;
  } mmst_row_t;

  logic       mclk, reset_n, mrst_n, sel_n, lp_req;
  logic       int_n, bus_en, low_pwr, dnr;
  logic [3:0] flags, masks;
  wire        bus_clk, wr_stb, wr_pdown, rd_stb;
  wire  [3:0] wr_mask, rd_flags;
  mmst_cond_t cond;
  int         n_mismatch, n_tests;
  mmst_row_t  rows [7] = '{'{4'h1, 4'h0, 1'b0}, '{4'h2, 4'h0, 1'b0},
    '{4'h4, 4'h0, 1'b0}, '{4'h8, 4'h0, 1'b0}, '{4'h1, 4'h1, 1'b1},
    '{4'h2, 4'hD, 1'b0}, '{4'h1, 4'hF, 1'b1}};

  mmst_top #(.INIT_US(20)) i_dut (.MCLK(mclk), .RESET_N(reset_n),
    .MODULE_RESET_LOW(mrst_n), .MODULE_SELECT_LOW(sel_n),
    .LOW_POWER_REQUEST(lp_req), .INTERRUPT_OUT_LOW(int_n), .BUS_CLK(bus_clk),
    .BUS_WR_STB(wr_stb), .BUS_WR_MASK(wr_mask), .BUS_WR_PDOWN(wr_pdown),
    .BUS_RD_STB(rd_stb), .BUS_RD_FLAGS(rd_flags), .COND(cond),
    .BUS_ENABLE(bus_en), .LOW_POWER(low_pwr), .DATA_NOT_READY(dnr),
    .FLAGS(flags), .MASKS(masks));

  mmst_host_model i_host (.bus_clk(bus_clk), .wr_stb(wr_stb), .wr_mask(wr_mask),
    .wr_pdown(wr_pdown), .rd_stb(rd_stb), .rd_flags(rd_flags));

  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  task chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask : chk

  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step

  function automatic logic pick(input int id);
    case (id)
      0: return dnr;
      1: return int_n;
      2: return bus_en;
      default: return low_pwr;
    endcase
  endfunction : pick

  // bounded wait for a status output to reach a level
  task wt(input int id, input logic v, input int n);
    int k;
    k = 0;
    while (pick(id) !== v && k < n) begin
      @(posedge mclk);
      #1;
      k++;
    end
  endtask : wt

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // bus clock falls during reset
  initial i_host.frame(1'b0, 4'h0, 1'b0);

  initial begin
    #500000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    reset_n    = 1'b0;
    mrst_n     = 1'b1;
    sel_n      = 1'b0;
    lp_req     = 1'b0;
    cond       = '0;
    n_mismatch = 0;
    n_tests    = 0;
    step(8);
    chk("reset", 12'h900, {int_n, bus_en, low_pwr, dnr, flags, masks});
    reset_n = 1'b1;
    wt(0, 1'b0, 2300);
    chk("dnr", 12'h0, dnr);
    wt(1, 1'b0, 10);
    chk("int_ready", 12'h0, int_n);
    wt(2, 1'b1, 1100);
    chk("bus_en", 12'h1, bus_en);
    i_host.frame(1'b0, 4'hF, 1'b0);
    step(10);
    chk("int_rd", 12'h1, int_n);
    foreach (rows[i]) begin
      i_host.frame(1'b1, rows[i].mask, 1'b0);
      step(10);
      cond.cond = rows[i].cond;
      step(20);
      chk("masks", rows[i].mask, masks);
      chk("flags", rows[i].cond, flags);
      chk("int", rows[i].int_exp, int_n);
      cond.cond = 4'h0;
      step(5);
      i_host.frame(1'b0, 4'hF, 1'b0);
      step(10);
      chk("clear", 12'h010, {int_n, flags});
    end
    // masked flag pending, then unmasked; a read while it stands keeps it
    cond.cond = 4'h1;
    step(20);
    chk("masked", 12'h1, int_n);
    i_host.frame(1'b1, 4'h0, 1'b0);
    step(10);
    chk("unmask", 12'h0, int_n);
    i_host.frame(1'b0, 4'h1, 1'b0);
    step(10);
    chk("set_wins", 12'h1, flags);
    cond.cond = 4'h0;
    step(5);
    i_host.frame(1'b0, 4'h1, 1'b0);
    step(10);
    chk("cleared", 12'h010, {int_n, flags});
    sel_n = 1'b1;
    wt(2, 1'b0, 10100);
    chk("bus_off", 12'h0, bus_en);
    sel_n = 1'b0;
    wt(2, 1'b1, 10100);
    chk("bus_on", 12'h1, bus_en);
    i_host.frame(1'b1, 4'h5, 1'b1);
    step(10);
    chk("pdown", 12'h1, low_pwr);
    i_host.frame(1'b1, 4'h5, 1'b0);
    step(10);
    chk("pdown_off", 12'h0, low_pwr);
    i_host.frame(1'b1, 4'h5, 1'b1);
    step(10);
    chk("pdown_again", 12'h1, low_pwr);
    // pulse below the minimum must not reset
    mrst_n = 1'b0;
    step(150);
    mrst_n = 1'b1;
    step(5);
    chk("short_rst", 12'h00B, {dnr, masks, low_pwr});
    mrst_n = 1'b0;
    step(250);
    mrst_n = 1'b1;
    step(5);
    chk("mreset", 12'h010, {dnr, masks});
    wt(0, 1'b0, 2300);
    chk("reinit", 12'h0, {dnr, low_pwr});
    lp_req = 1'b1;
    wt(3, 1'b1, 10100);
    chk("lp_pin", 12'h1, low_pwr);
    stop_test();
  end
endmodule : testbench
